// ===== rtl/esb_params.svh
/*
 Timing counts, field positions and fixed values for the serial memory
 front end and its bus master. Assumes a 250 MHz system clock and is
 included by bare name from the design modules and the bench.
*/
// Overview of operation
// - Program cycle starts at write STOP, ends within 10 ms.
// - While programming, ignore address and release data line.
// - Master alone makes clock, START and STOP.
// - Master picks direction; device follows as receiver/transmitter.
// - Every bit is timed by the serial clock.
// - Data line is only pulled low or released.
// - Write protect low permits writes everywhere.
// - Write protect high blocks all programming.
// - Floating write protect counts as unprotected.
// - Master starts transfers only on an idle bus.
// - Data stays steady while the clock is high.
// - Data change with clock high is START or STOP.
// - START is data falling while clock high.
// - Commands begin with START; silent until one.
// - STOP is data rising while clock high.
// - Master ends every operation with STOP.
// - Master waits out power-up delay before first access.
// - First byte is address plus direction; match required.
// - Receiver acknowledges each byte on ninth clock.
// - Protected: ack addresses, refuse first data byte.
// - Address polling refused while programming, acked after.
`ifndef ESB_PARAMS_SVH
`define ESB_PARAMS_SVH
`define ESB_CLK_MHZ 250
`define ESB_PROGRAM_CYCLE_TIME_MS 10
`define ESB_PROG_CYC (`ESB_PROGRAM_CYCLE_TIME_MS * 1000 * `ESB_CLK_MHZ)
`define ESB_POWERUP_TO_READ_DELAY_MS 1
`define ESB_POWERUP_TO_WRITE_DELAY_MS 1
`define ESB_PWRUP_CYC (`ESB_POWERUP_TO_WRITE_DELAY_MS * 1000 * `ESB_CLK_MHZ)
`define ESB_SCL_KHZ 400
`define ESB_QTR_CYC ((`ESB_CLK_MHZ * 1000) / (4 * `ESB_SCL_KHZ))
`define ESB_FILT_LEN 2
`define ESB_SLAVE_ADDR 7'h2B
`define ESB_BITS_BYTE 4'h8
`define ESB_LAST_TX_BIT 4'h7
`define ESB_DATA_BYTE 2'h2
`endif

// ===== rtl/esb_pkg.sv
/*
 Types shared by both ends of the serial memory link.
 Assumes the constants header is on the include path.
*/
`default_nettype none
package esb_pkg;
   // Device link states, one-hot.
   typedef enum logic [5:0] {
      D_IDLE = 6'h01, D_ADDR = 6'h02, D_ACK = 6'h04,
      D_WRX = 6'h08, D_TX = 6'h10, D_RACK = 6'h20
   } esb_dst_t;
   // Master states, one-hot.
   typedef enum logic [4:0] {
      H_WAIT = 5'h01, H_IDLE = 5'h02, H_START = 5'h04,
      H_BIT = 5'h08, H_STOP = 5'h10
   } esb_hst_t;
   // Master user commands.
   typedef enum logic [1:0] {
      CMD_START = 2'h0, CMD_WRITE = 2'h1, CMD_READ = 2'h2, CMD_STOP = 2'h3
   } esb_cmd_t;
endpackage : esb_pkg
`default_nettype wire

// ===== rtl/esb_link_if.sv
/*
 The two-wire link between master and memory front end.
 Assumes both ends drive data open-drain; the wire level is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface esb_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;
   // Wired-AND of the two open-drain drivers with a pull-up.
   assign sda = ((!host_sda_oe_n && !host_sda_o) ||
                 (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;
   modport host (output scl, output host_sda_o, output host_sda_oe_n,
                 input sda);
   modport dev (input scl, input sda, output dev_sda_o,
                output dev_sda_oe_n);
endinterface : esb_link_if
`default_nettype wire

// ===== rtl/esb_filt.sv
/*
 Two-flop synchroniser followed by a stable-count glitch filter per bit.
 Assumes reset and enable are already in this clock's domain.
*/
`timescale 1ns/1ps
`default_nettype none
module esb_filt #(
   parameter int W = 2,
   parameter int LEN = 2
) (
   // Clock and control
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Raw and cleaned levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   localparam int CW = $clog2(LEN + 1);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] q;
      logic [W-1:0][CW-1:0] cnt;
   } esb_filt_t;
   esb_filt_t f_r, f_nxt;

   // A level only moves after it has stood for LEN samples.
   always_comb begin
      f_nxt = f_r;
      if (reset) begin
         // Start at the idle high level so release makes no false edge.
         f_nxt = '0;
         f_nxt.s1 = '1;
         f_nxt.s2 = '1;
         f_nxt.q = '1;
      end else if (ce) begin
         f_nxt.s1 = d;
         f_nxt.s2 = f_r.s1;
         for (int i = 0; i < W; i++) begin
            if (f_r.s2[i] == f_r.q[i]) begin
               f_nxt.cnt[i] = '0;
            end else if (f_r.cnt[i] == CW'(LEN - 1)) begin
               f_nxt.q[i] = f_r.s2[i];
               f_nxt.cnt[i] = '0;
            end else begin
               f_nxt.cnt[i] = f_r.cnt[i] + 1'b1;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      f_r <= f_nxt;
   end

   assign q = f_r.q;
endmodule : esb_filt
`default_nettype wire

// ===== rtl/esb_dev.sv
/*
 Slave front end of the serial memory: bus conditions, bit shifting,
 acknowledge, write protect and the self-timed program cycle.
 Assumes clk_link runs freely and much faster than the serial clock;
 user side is on clk_sys, and tx_data is sampled on the clk_sys edge that raises tx_taken.
*/
`timescale 1ns/1ps
`default_nettype none
`include "esb_params.svh"
module esb_dev
   import esb_pkg::*;
#(
   parameter int PROG_CYC = `ESB_PROG_CYC,
   parameter int PWRUP_CYC = `ESB_PWRUP_CYC,
   parameter int FILT_LEN = `ESB_FILT_LEN,
   parameter logic [6:0] SLAVE_ADDR = `ESB_SLAVE_ADDR
) (
   // System side clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   // Link clock that samples the bus
   input wire logic clk_link,
   // Bus pins
   esb_link_if.dev link,
   input wire logic wp,
   // Received bytes
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Bytes to transmit
   input wire logic [7:0] tx_data,
   output logic tx_taken,
   // Program cycle
   output logic prog_start,
   output logic busy
);
   localparam int TW = $clog2(PROG_CYC + PWRUP_CYC + 1);

   typedef struct packed {
      logic [1:0] rst_s;
      logic [1:0] ce_s;
      logic [1:0] busy_s;
      logic [1:0] wp_s;
      logic [2:0] tack_s;
      logic scl_p;
      logic sda_p;
      esb_dst_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic mack;
      logic [1:0] nbyte;
      logic wr_pend;
      logic [7:0] rx_hold;
      logic rx_tgl;
      logic prog_tgl;
      logic treq_tgl;
      logic [7:0] tx_buf;
      logic oe_n;
      logic o;
   } esb_dlink_t;

   typedef struct packed {
      logic [2:0] rx_s;
      logic [2:0] prog_s;
      logic [2:0] treq_s;
      logic [7:0] rx_data_r;
      logic rx_valid_r;
      logic [7:0] tx_hold;
      logic tack_tgl;
      logic tx_taken_r;
      logic prog_start_r;
      logic [TW-1:0] timer;
      logic busy_r;
   } esb_dsys_t;

   esb_dlink_t l_r, l_nxt;
   esb_dsys_t s_r, s_nxt;
   logic scl_f, sda_f;
   logic lrst, lce;
   logic start, stop, rise, fall;

   assign lrst = l_r.rst_s[1];
   assign lce = l_r.ce_s[1];

   // Pins are cleaned on the link clock before any edge is taken.
   esb_filt #(.W(2), .LEN(FILT_LEN)) u_filt (
      .clk(clk_link),
      .reset(lrst),
      .ce(lce),
      .d({link.scl, link.sda}),
      .q({scl_f, sda_f})
   );

   // Data moving while the clock stays high is a condition, never a bit.
   assign start = scl_f && l_r.scl_p && l_r.sda_p && !sda_f;
   assign stop = scl_f && l_r.scl_p && !l_r.sda_p && sda_f;
   assign rise = scl_f && !l_r.scl_p;
   assign fall = !scl_f && l_r.scl_p;

   // Link domain: bit engine, acknowledge and condition handling.
   always_comb begin
      l_nxt = l_r;
      l_nxt.rst_s = {l_r.rst_s[0], reset};
      l_nxt.ce_s = {l_r.ce_s[0], ce};
      if (lrst) begin
         l_nxt.busy_s = 2'h3;
         l_nxt.wp_s = '0;
         l_nxt.tack_s = '0;
         l_nxt.scl_p = 1'b1;
         l_nxt.sda_p = 1'b1;
         l_nxt.st = D_IDLE;
         l_nxt.cnt = '0;
         l_nxt.sh = '0;
         l_nxt.rw = 1'b0;
         l_nxt.mack = 1'b0;
         l_nxt.nbyte = '0;
         l_nxt.wr_pend = 1'b0;
         l_nxt.rx_hold = '0;
         l_nxt.rx_tgl = 1'b0;
         l_nxt.prog_tgl = 1'b0;
         l_nxt.treq_tgl = 1'b0;
         l_nxt.tx_buf = '0;
         l_nxt.oe_n = 1'b1;
         l_nxt.o = 1'b0;
      end else if (lce) begin
         l_nxt.busy_s = {l_r.busy_s[0], s_r.busy_r};
         l_nxt.wp_s = {l_r.wp_s[0], wp};
         l_nxt.tack_s = {l_r.tack_s[1:0], s_r.tack_tgl};
         l_nxt.scl_p = scl_f;
         l_nxt.sda_p = sda_f;
         // The system side holds the word steady across its toggle.
         if (l_r.tack_s[2] != l_r.tack_s[1]) begin
            l_nxt.tx_buf = s_r.tx_hold;
         end
         case (l_r.st)
            D_IDLE: begin
               l_nxt.oe_n = 1'b1;
            end
            D_ADDR, D_WRX: begin
               if (rise) begin
                  l_nxt.sh = {l_r.sh[6:0], sda_f};
                  l_nxt.cnt = l_r.cnt + 1'b1;
               end else if (fall && l_r.cnt == `ESB_BITS_BYTE) begin
                  l_nxt.cnt = '0;
                  if (l_r.st == D_ADDR) begin
                     // Polls are refused until the cycle ends.
                     if (l_r.sh[7:1] == SLAVE_ADDR && !l_r.busy_s[1]) begin
                        l_nxt.st = D_ACK;
                        l_nxt.oe_n = 1'b0;
                        l_nxt.rw = l_r.sh[0];
                        l_nxt.nbyte = '0;
                        l_nxt.treq_tgl = l_r.treq_tgl ^ l_r.sh[0];
                     end else begin
                        l_nxt.st = D_IDLE;
                     end
                  end else if (l_r.nbyte == `ESB_DATA_BYTE &&
                               l_r.wp_s[1]) begin
                     // Only a solid high protects; low or open writes.
                     l_nxt.st = D_IDLE;
                  end else begin
                     l_nxt.st = D_ACK;
                     l_nxt.oe_n = 1'b0;
                     l_nxt.rx_hold = l_r.sh;
                     l_nxt.rx_tgl = !l_r.rx_tgl;
                     if (l_r.nbyte == `ESB_DATA_BYTE) begin
                        l_nxt.wr_pend = 1'b1;
                     end else begin
                        l_nxt.nbyte = l_r.nbyte + 1'b1;
                     end
                  end
               end
            end
            D_ACK: begin
               if (fall) begin
                  l_nxt.cnt = '0;
                  if (l_r.rw) begin
                     l_nxt.st = D_TX;
                     l_nxt.sh = l_r.tx_buf;
                     l_nxt.oe_n = l_r.tx_buf[7];
                  end else begin
                     l_nxt.st = D_WRX;
                     l_nxt.oe_n = 1'b1;
                  end
               end
            end
            D_TX: begin
               if (fall) begin
                  if (l_r.cnt == `ESB_LAST_TX_BIT) begin
                     l_nxt.st = D_RACK;
                     l_nxt.oe_n = 1'b1;
                     l_nxt.treq_tgl = !l_r.treq_tgl;
                  end else begin
                     l_nxt.sh = {l_r.sh[6:0], 1'b0};
                     l_nxt.oe_n = l_r.sh[6];
                     l_nxt.cnt = l_r.cnt + 1'b1;
                  end
               end
            end
            D_RACK: begin
               if (rise) begin
                  l_nxt.mack = !sda_f;
               end else if (fall) begin
                  l_nxt.cnt = '0;
                  if (l_r.mack) begin
                     l_nxt.st = D_TX;
                     l_nxt.sh = l_r.tx_buf;
                     l_nxt.oe_n = l_r.tx_buf[7];
                  end else begin
                     l_nxt.st = D_IDLE;
                  end
               end
            end
            default: begin
               l_nxt.st = D_IDLE;
               l_nxt.oe_n = 1'b1;
            end
         endcase
         // A START mid-byte drops whatever was under way; a STOP drops the byte but starts any pending write.
         if (start) begin
            l_nxt.st = D_ADDR;
            l_nxt.cnt = '0;
            l_nxt.oe_n = 1'b1;
            l_nxt.wr_pend = 1'b0;
         end else if (stop) begin
            l_nxt.st = D_IDLE;
            l_nxt.oe_n = 1'b1;
            l_nxt.wr_pend = 1'b0;
            l_nxt.prog_tgl = l_r.prog_tgl ^ l_r.wr_pend;
         end
      end
   end

   // Link domain register.
   always_ff @(posedge clk_link) begin
      l_r <= l_nxt;
   end

   // System domain: event toggles arrive here through two flops each.
   always_comb begin
      s_nxt = s_r;
      if (reset) begin
         s_nxt = '0;
         s_nxt.timer = TW'(PWRUP_CYC);
         s_nxt.busy_r = 1'b1;
      end else if (ce) begin
         s_nxt.rx_s = {s_r.rx_s[1:0], l_r.rx_tgl};
         s_nxt.prog_s = {s_r.prog_s[1:0], l_r.prog_tgl};
         s_nxt.treq_s = {s_r.treq_s[1:0], l_r.treq_tgl};
         s_nxt.rx_valid_r = s_r.rx_s[2] ^ s_r.rx_s[1];
         if (s_r.rx_s[2] ^ s_r.rx_s[1]) begin
            s_nxt.rx_data_r = l_r.rx_hold;
         end
         s_nxt.tx_taken_r = s_r.treq_s[2] ^ s_r.treq_s[1];
         if (s_r.treq_s[2] ^ s_r.treq_s[1]) begin
            s_nxt.tx_hold = tx_data;
            s_nxt.tack_tgl = !s_r.tack_tgl;
         end
         s_nxt.prog_start_r = s_r.prog_s[2] ^ s_r.prog_s[1];
         // Count floors the time, so the cycle never overruns.
         if (s_r.prog_s[2] ^ s_r.prog_s[1]) begin
            s_nxt.timer = TW'(PROG_CYC);
         end else if (s_r.timer != '0) begin
            s_nxt.timer = s_r.timer - 1'b1;
         end
         s_nxt.busy_r = (s_nxt.timer != '0);
      end
   end

   // System domain register.
   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   assign link.dev_sda_o = l_r.o;
   assign link.dev_sda_oe_n = l_r.oe_n;
   assign rx_data = s_r.rx_data_r;
   assign rx_valid = s_r.rx_valid_r;
   assign tx_taken = s_r.tx_taken_r;
   assign prog_start = s_r.prog_start_r;
   assign busy = s_r.busy_r;
endmodule : esb_dev
`default_nettype wire

// ===== rtl/esb_host.sv
/*
 Bus master end: makes the serial clock by dividing clk_sys and drives
 START, STOP and byte transfers on user commands.
 Assumes a single command is offered at a time against cmd_ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "esb_params.svh"
module esb_host
   import esb_pkg::*;
#(
   parameter int QTR_CYC = `ESB_QTR_CYC,
   parameter int PWRUP_CYC = `ESB_PWRUP_CYC
) (
   // Clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   // Bus pins
   esb_link_if.host link,
   // Commands
   input wire logic cmd_valid,
   input wire esb_cmd_t cmd,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_mack,
   output logic cmd_ready,
   // Answers
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_nack
);
   localparam int QW = $clog2(QTR_CYC + 1);
   localparam int PW = $clog2(PWRUP_CYC + 1);

   typedef struct packed {
      esb_hst_t st;
      logic [QW-1:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [8:0] tx;
      logic [8:0] rx;
      logic [1:0] sda_s;
      logic [PW-1:0] pw;
      logic scl;
      logic oe_n;
      logic o;
      logic ready;
      logic rvalid;
      logic [7:0] rdata;
      logic rnack;
   } esb_hreg_t;
   esb_hreg_t h_r, h_nxt;
   logic tick;

   assign tick = (h_r.qcnt == '0);

   // Each step is four quarters of the serial clock period.
   always_comb begin
      h_nxt = h_r;
      if (reset) begin
         h_nxt = '0;
         h_nxt.st = H_WAIT;
         h_nxt.pw = PW'(PWRUP_CYC);
         h_nxt.scl = 1'b1;
         h_nxt.oe_n = 1'b1;
         h_nxt.sda_s = 2'h3;
      end else if (ce) begin
         h_nxt.sda_s = {h_r.sda_s[0], link.sda};
         h_nxt.rvalid = 1'b0;
         if (h_r.st != H_WAIT && h_r.st != H_IDLE) begin
            h_nxt.qcnt = tick ? QW'(QTR_CYC - 1) : h_r.qcnt - 1'b1;
            if (tick) begin
               h_nxt.ph = h_r.ph + 1'b1;
            end
         end
         case (h_r.st)
            H_WAIT: begin
               if (h_r.pw == '0) begin
                  h_nxt.st = H_IDLE;
                  h_nxt.ready = 1'b1;
               end else begin
                  h_nxt.pw = h_r.pw - 1'b1;
               end
            end
            H_IDLE: begin
               if (cmd_valid) begin
                  h_nxt.ready = 1'b0;
                  h_nxt.qcnt = QW'(QTR_CYC - 1);
                  h_nxt.ph = '0;
                  h_nxt.bitn = '0;
                  // A read releases data and drives only the ack bit.
                  h_nxt.tx = (cmd == CMD_READ) ? {8'hFF, !cmd_mack} :
                             {cmd_data, 1'b1};
                  case (cmd)
                     CMD_START: h_nxt.st = H_START;
                     CMD_STOP: h_nxt.st = H_STOP;
                     default: h_nxt.st = H_BIT;
                  endcase
               end
            end
            H_START: begin
               if (tick) begin
                  case (h_r.ph)
                     2'h0: h_nxt.oe_n = 1'b1;
                     2'h1: h_nxt.scl = 1'b1;
                     2'h2: h_nxt.oe_n = 1'b0;
                     default: begin
                        h_nxt.scl = 1'b0;
                        h_nxt.st = H_BIT;
                     end
                  endcase
               end
            end
            H_BIT: begin
               if (tick) begin
                  case (h_r.ph)
                     2'h0: h_nxt.oe_n = h_r.tx[8];
                     2'h1: h_nxt.scl = 1'b1;
                     2'h2: h_nxt.rx = {h_r.rx[7:0], h_r.sda_s[1]};
                     default: begin
                        h_nxt.scl = 1'b0;
                        h_nxt.tx = {h_r.tx[7:0], 1'b1};
                        if (h_r.bitn == `ESB_BITS_BYTE) begin
                           h_nxt.st = H_IDLE;
                           h_nxt.ready = 1'b1;
                           h_nxt.rvalid = 1'b1;
                           h_nxt.rdata = h_r.rx[8:1];
                           h_nxt.rnack = h_r.rx[0];
                        end else begin
                           h_nxt.bitn = h_r.bitn + 1'b1;
                        end
                     end
                  endcase
               end
            end
            H_STOP: begin
               if (tick) begin
                  case (h_r.ph)
                     2'h0: h_nxt.oe_n = 1'b0;
                     2'h1: h_nxt.scl = 1'b1;
                     2'h2: h_nxt.oe_n = 1'b1;
                     default: begin
                        h_nxt.st = H_IDLE;
                        h_nxt.ready = 1'b1;
                     end
                  endcase
               end
            end
            default: h_nxt.st = H_IDLE;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      h_r <= h_nxt;
   end

   assign link.scl = h_r.scl;
   assign link.host_sda_o = h_r.o;
   assign link.host_sda_oe_n = h_r.oe_n;
   assign cmd_ready = h_r.ready;
   assign rsp_valid = h_r.rvalid;
   assign rsp_data = h_r.rdata;
   assign rsp_nack = h_r.rnack;
endmodule : esb_host
`default_nettype wire

// ===== verification/esb_link_sva.sv
/*
 Checker for the two-wire link: open-drain use, data timing, conditions.
 Assumes the link signals and the host's system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module esb_link_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Link wires
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic sda
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [8:0] hi_cnt_r;
   // Time the clock has stood high; longer than 200 cycles means idle bus.
   always_ff @(posedge clk_sys) begin
      if (reset || !scl) hi_cnt_r <= 9'h000;
      else if (hi_cnt_r != 9'h1FF) hi_cnt_r <= hi_cnt_r + 9'h001;
   end
   AST_DEV_OD: assert property (dev_sda_o == 1'b0)
      else $error("device drives data high");
   AST_HOST_OD: assert property (host_sda_o == 1'b0)
      else $error("host drives data high");
   AST_DEV_CHG_LOW: assert property (
      $changed(dev_sda_oe_n) |-> !scl)
      else $error("device data moved with clock high");
   AST_DEV_NO_COND: assert property (
      scl && $past(scl) |-> $stable(dev_sda_oe_n))
      else $error("device made a bus condition");
   AST_DEV_IDLE: assert property (hi_cnt_r > 9'h0C8 |-> dev_sda_oe_n)
      else $error("device holds data on idle bus");
   AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   AST_START: assert property (
      $fell(sda) && scl && $past(scl) |=> scl [*8])
      else $error("start not held");
   AST_STOP: assert property (
      $rose(sda) && scl && $past(scl) |=> scl [*8])
      else $error("stop not held");
   AST_START_HOST: assert property (
      $fell(sda) && scl |-> dev_sda_oe_n)
      else $error("start made while device drives");
   AST_HOST_SETUP: assert property (
      $rose(scl) |-> $stable(host_sda_oe_n))
      else $error("host data moved as clock rose");
endmodule : esb_link_sva
`default_nettype wire

// ===== verification/tb_eeprom_serial_bus_front_end.sv
/*
 Bench joining master and memory front end over the link interface.
 Assumes shortened timing parameters; a floating protect pin is driven 0.
*/
`timescale 1ns/1ps
`default_nettype none
`include "esb_params.svh"
module tb_eeprom_serial_bus_front_end;
   import esb_pkg::*;
   localparam int PROG = 4000;
   localparam logic [7:0] AW = {`ESB_SLAVE_ADDR, 1'b0};
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic reset = 1'b1;
   logic wp = 1'b0;
   logic cmd_valid = 1'b0;
   esb_cmd_t cmd = CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_mack = 1'b0;
   logic [7:0] tx_data = 8'hC3;
   logic cmd_ready, rsp_valid, rsp_nack, rx_valid, tx_taken;
   logic prog_start, busy;
   logic [7:0] rsp_data, rx_data, rx_last;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int rx_cnt = 0;
   int prog_cnt = 0;
   int prog_at = 0;
   int tx_cnt = 0;
   int rel_at = 0;
   esb_link_if u_esb_link_if ();
   esb_host #(.QTR_CYC(64), .PWRUP_CYC(50)) u_esb_host (.clk_sys(clk_sys),
      .reset(reset), .ce(1'b1), .link(u_esb_link_if), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_data(cmd_data), .cmd_mack(cmd_mack),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_nack(rsp_nack));
   esb_dev #(.PROG_CYC(PROG), .PWRUP_CYC(50)) u_esb_dev (.clk_sys(clk_sys),
      .reset(reset), .ce(1'b1), .clk_link(clk_link), .link(u_esb_link_if),
      .wp(wp), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
      .tx_taken(tx_taken), .prog_start(prog_start), .busy(busy));
   esb_link_sva u_esb_link_sva (.clk_sys(clk_sys), .reset(reset),
      .scl(u_esb_link_if.scl), .host_sda_o(u_esb_link_if.host_sda_o),
      .host_sda_oe_n(u_esb_link_if.host_sda_oe_n),
      .dev_sda_o(u_esb_link_if.dev_sda_o),
      .dev_sda_oe_n(u_esb_link_if.dev_sda_oe_n), .sda(u_esb_link_if.sda));
   // System clock; the link clock is offset so the phases never line up.
   always #2 clk_sys = ~clk_sys;
   initial begin
      #1.3;
      forever #32 clk_link = ~clk_link;
   end
   // Records received bytes and program starts; cuts a hang short.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) begin
         rx_cnt <= rx_cnt + 1;
         rx_last <= rx_data;
      end
      if (tx_taken === 1'b1) tx_cnt <= tx_cnt + 1;
      if (prog_start === 1'b1) begin
         prog_cnt <= prog_cnt + 1;
         prog_at <= cyc;
      end
      if (cyc == 60000) begin
         num_errors++;
         summarize();
      end
   end
   // Four-state arguments so an unknown value never passes as zero.
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk
   // Waits past edges for ready, answer or idle, under a bounded count.
   task automatic wait_for(input int w);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (!((w == 0 && cmd_ready === 1'b1) ||
                   (w == 1 && rsp_valid === 1'b1) ||
                   (w == 2 && busy === 1'b0)) && n < 20000);
      if (n >= 20000) chk("handshake wait", 0, 1);
   endtask : wait_for
   // One master command; checks the ninth bit or the byte read back.
   task automatic op(input esb_cmd_t c, input logic [7:0] d,
                     input logic m, input logic nack);
      wait_for(0);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_data = d;
      cmd_mack = m;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      wait_for(c == CMD_STOP ? 0 : 1);
      if (c == CMD_READ) chk("read byte", tx_data, rsp_data);
      else if (c != CMD_STOP) chk("ninth bit", nack, rsp_nack);
   endtask : op
   task automatic summarize();
      $display("Errors %0d in %0d checks", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // Main sequence: reset long enough for both domains, then transfers.
   initial begin
      repeat (6) @(posedge clk_link);
      @(posedge clk_sys);
      #1;
      reset = 1'b0;
      rel_at = cyc;
      wait_for(0);
      chk("power-up delay", 1, cyc - rel_at >= 50);
      op(CMD_START, 8'h22, 1'b0, 1'b1);
      op(CMD_STOP, 8'h00, 1'b0, 1'b0);
      op(CMD_START, AW, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h00, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h10, 1'b0, 1'b0);
      op(CMD_WRITE, 8'hA5, 1'b0, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0, 1'b0);
      chk("bytes received", 3, rx_cnt);
      chk("last byte", 8'hA5, rx_last);
      op(CMD_START, AW, 1'b0, 1'b1);
      chk("program started", 1, prog_cnt);
      op(CMD_STOP, 8'h00, 1'b0, 1'b0);
      wait_for(2);
      chk("program bound", 1, cyc - prog_at <= PROG + 8);
      wp = 1'b1;
      op(CMD_START, AW, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h00, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h20, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h5A, 1'b0, 1'b1);
      op(CMD_STOP, 8'h00, 1'b0, 1'b0);
      wp = 1'b0; // An open pin reads low here.
      op(CMD_START, AW, 1'b0, 1'b0);
      chk("protected write", 1, prog_cnt);
      op(CMD_WRITE, 8'h00, 1'b0, 1'b0);
      op(CMD_WRITE, 8'h00, 1'b0, 1'b0);
      op(CMD_START, AW | 8'h01, 1'b0, 1'b0);
      op(CMD_READ, 8'h00, 1'b1, 1'b0);
      op(CMD_READ, 8'h00, 1'b0, 1'b0);
      op(CMD_STOP, 8'h00, 1'b0, 1'b0);
      chk("no program after read", 1, prog_cnt);
      chk("tx bytes taken", 3, tx_cnt);
      summarize();
   end
endmodule : tb_eeprom_serial_bus_front_end
`default_nettype wire
